// File: design/dvrpos_pkg.sv
// Shared constants and types of the DVI receive pixel output stage
package dvrpos_pkg;

  // Pixel and lane layout
  localparam int PIX_W = 24;
  localparam int LANE_W = 8;
  localparam int BLUE_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int RED_LSB = 16;
  localparam int CTL_W = 3;

  // Register bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_PIXSEL_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_PD_BIT = 2;
  localparam int CTRL_PDO_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'hc;

  // Status register fields
  localparam int STAT_W = 4;
  localparam int STAT_SYNC_DETECT_OUTPUT_BIT = 0;
  localparam int STAT_DUAL_BIT = 1;
  localparam int STAT_POL_BIT = 2;
  localparam int STAT_RUN_BIT = 3;

  // Position of the incoming pixel within an even/odd pair
  typedef enum logic {
    DVRPOS_PH_EVEN = 1'b0,
    DVRPOS_PH_ODD = 1'b1
  } dvrpos_phase_t;

endpackage

// File: design/dvrpos_cells.sv
// Level synchroniser and even/odd pixel pairing for the pixel output stage
`timescale 1ns/1ps

module dvrpos_sync #(
  parameter int W = 1 // Number of independent level bits
) (
  input wire logic clk_i, // Destination clock
  input wire logic [W-1:0] async_i, // Levels from another domain
  output logic [W-1:0] sync_o // Levels safe to use in clk_i domain
);

  logic [W-1:0] meta_q; // First stage, read only by the second stage
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q; // Second stage
  logic [W-1:0] sync_d;

  // Next values: plain shift, no logic on the first stage
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // No reset here, so the same cell can carry a reset across domains
  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_o = sync_q;

endmodule // dvrpos_sync

module dvrpos_pack import dvrpos_pkg::*; #(
  parameter int PW = PIX_W // Pixel width
) (
  input wire logic clk_i, // Recovered pixel clock
  input wire logic clear_i, // Reset or power down, clears the pairing
  input wire logic dual_i, // Two pixels per output clock
  input wire logic de_i, // Incoming display enable
  input wire logic [PW-1:0] data_i, // Incoming pixel
  output logic launch_o, // Output registers load this cycle
  output logic [PW-1:0] even_o // Held even pixel of the current pair
);

  dvrpos_phase_t phase_q; // Phase the next pixel would take
  dvrpos_phase_t phase_d;
  dvrpos_phase_t eff_phase; // Phase of the pixel present now
  logic de_prev_q; // Display enable one pixel ago
  logic de_prev_d;
  logic [PW-1:0] hold_q; // Even pixel waiting for its odd partner
  logic [PW-1:0] hold_d;

  // Pairing: a line always starts on an even pixel
  always_comb begin
    de_prev_d = de_i;
    eff_phase = (de_i && !de_prev_q) ? DVRPOS_PH_EVEN : phase_q;
    phase_d = DVRPOS_PH_EVEN;
    hold_d = hold_q;
    case (eff_phase)
      DVRPOS_PH_EVEN: begin
        // Park the even pixel when pairing, else pass straight through
        if (dual_i) begin
          phase_d = DVRPOS_PH_ODD;
          hold_d = data_i;
        end
      end
      DVRPOS_PH_ODD: begin
        phase_d = DVRPOS_PH_EVEN;
      end
      default: begin
        phase_d = DVRPOS_PH_EVEN;
      end
    endcase
    launch_o = !dual_i || (eff_phase == DVRPOS_PH_ODD);
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      phase_q <= DVRPOS_PH_EVEN;
      de_prev_q <= 1'b0;
      hold_q <= '0;
    end else begin
      phase_q <= phase_d;
      de_prev_q <= de_prev_d;
      hold_q <= hold_d;
    end
  end

  assign even_o = hold_q;

endmodule // dvrpos_pack

// File: design/dvrpos_top.sv
// Pixel output stage of a DVI receiver with a Wishbone control port
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps

module dvrpos_top import dvrpos_pkg::*; (
  input wire logic clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [ADR_W-1:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [DAT_W-1:0] wb_dat_i, // Wishbone write data
  output logic [DAT_W-1:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic pix_clk_i, // Recovered pixel clock
  input wire logic [PIX_W-1:0] pix_data_i, // Decoded pixel, red high
  input wire logic pix_de_i, // Decoded display enable
  input wire logic pix_hsync_i, // Decoded horizontal sync
  input wire logic pix_vsync_i, // Decoded vertical sync
  input wire logic [CTL_W-1:0] pix_ctl_i, // Decoded control bits
  input wire logic pix_sync_detect_i, // Link sync detected
  output logic [PIX_W-1:0] even_pixel_bus_o, // Even pixel bus
  output logic even_pixel_bus_oe_o, // Even bus drive enable
  output logic [PIX_W-1:0] odd_pixel_bus_o, // Odd pixel bus
  output logic odd_pixel_bus_oe_o, // Odd bus drive enable
  output logic output_pixel_clock_o, // Output pixel clock
  output logic output_pixel_clock_oe_o, // Output clock drive enable
  output logic display_enable_out_o, // Display enable
  output logic hsync_o, // Horizontal sync
  output logic vsync_o, // Vertical sync
  output logic timing_oe_o, // Enable, sync drive enable
  output logic [CTL_W-1:0] general_control_outputs_o, // Control lines
  output logic [CTL_W-1:0] general_control_outputs_oe_o, // Their enables
  output logic sync_detect_output_o, // Sync detect
  output logic sync_detect_output_oe_o // Sync detect drive enable
);

  // System clock domain
  logic [CTRL_W-1:0] ctrl_q, ctrl_d; // Mode and power straps
  logic ack_q, ack_d; // Bus acknowledge
  logic [DAT_W-1:0] rdat_q, rdat_d; // Read data, valid with ack
  logic bus_req, ctrl_wr; // Request present; control write lands this edge
  logic [STAT_W-1:0] stat_s; // Pixel-side state, synchronised
  logic drv_on, pwr_on; // Powered with drivers on; powered

  // Bus decode: one wait state, writes land on the acknowledge edge
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i;
    ack_d = bus_req && !ack_q;
    ctrl_wr = bus_req && wb_we_i && ack_q && wb_sel_i[0] && (wb_adr_i == REG_CTRL);
    ctrl_d = ctrl_q;
    rdat_d = rdat_q;
    if (ctrl_wr) begin
      ctrl_d = wb_dat_i[CTRL_W-1:0];
    end
    if (bus_req && !ack_q) begin
      // Unmapped addresses still acknowledge, reading zero
      case (wb_adr_i)
        REG_CTRL: rdat_d = {{(DAT_W-CTRL_W){1'b0}}, ctrl_q};
        REG_STATUS: rdat_d = {{(DAT_W-STAT_W){1'b0}}, stat_s};
        default: rdat_d = '0;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Pad enables come straight from the control flops, so the pads
  // float at once even while the pixel clock is stopped
  always_comb begin
    pwr_on = ctrl_q[CTRL_PD_BIT];
    drv_on = ctrl_q[CTRL_PD_BIT] && ctrl_q[CTRL_PDO_BIT];
  end

  assign even_pixel_bus_oe_o = drv_on;
  assign odd_pixel_bus_oe_o = drv_on;
  assign output_pixel_clock_oe_o = drv_on;
  assign timing_oe_o = drv_on;
  // Control line 1 and sync detect stay up during drive power down
  assign general_control_outputs_oe_o = {drv_on, drv_on, pwr_on};
  assign sync_detect_output_oe_o = pwr_on;

  // Crossings between the two clock domains
  logic pix_rst_s; // Reset seen in the pixel domain
  logic [2:0] strap_s; // Straps seen in the pixel domain
  logic [STAT_W-1:0] stat_raw; // Pixel-side state before crossing
  logic dual_q, dual_d; // Dual pixel mode
  logic pol_q, pol_d; // Rising-edge latching selected
  logic run; // Pixel path active

  // Reset and straps are levels, so two flops suffice; the straps are
  // expected to be quiet when they change, so no bus coherence is needed
  dvrpos_sync #(.W(1)) u_rst_sync (
    .clk_i(pix_clk_i),
    .async_i(rst_i),
    .sync_o(pix_rst_s)
  );

  dvrpos_sync #(.W(3)) u_strap_sync (
    .clk_i(pix_clk_i),
    .async_i({ctrl_q[CTRL_PD_BIT], ctrl_q[CTRL_POL_BIT], ctrl_q[CTRL_PIXSEL_BIT]}),
    .sync_o(strap_s)
  );

  dvrpos_sync #(.W(STAT_W)) u_stat_sync (
    .clk_i(clk_i),
    .async_i(stat_raw),
    .sync_o(stat_s)
  );

  // Pixel clock domain
  logic pix_rst_q; // Local copy of the pixel-side reset
  logic run_q, run_d; // Powered, as seen by the pixel path
  logic launch; // Output registers load this cycle
  logic [PIX_W-1:0] pair_even; // Parked even pixel
  logic [PIX_W-1:0] even_q, even_d; // Even bus
  logic [PIX_W-1:0] odd_q, odd_d; // Odd bus
  logic de_q, de_d; // Display enable out
  logic hs_q, hs_d; // Horizontal sync out
  logic vs_q, vs_d; // Vertical sync out
  logic [CTL_W-1:0] ctl_q, ctl_d; // Control lines out
  logic sync_detect_output_q, sync_detect_output_d; // Sync detect out
  logic output_pixel_clock_q, output_pixel_clock_d; // Half-rate output clock phase in dual mode

  // Path runs only while powered and the local pixel-side reset is low
  assign run = run_q && !pix_rst_q;

  dvrpos_pack #(.PW(PIX_W)) u_pack (
    .clk_i(pix_clk_i),
    .clear_i(!run),
    .dual_i(dual_q),
    .de_i(pix_de_i),
    .data_i(pix_data_i),
    .launch_o(launch),
    .even_o(pair_even)
  );

  // Output next values; straps resampled once so all users agree
  always_comb begin
    dual_d = strap_s[0];
    pol_d = strap_s[1];
    run_d = strap_s[2];
    even_d = even_q;
    odd_d = odd_q;
    de_d = de_q;
    hs_d = hs_q;
    vs_d = vs_q;
    ctl_d = ctl_q;
    sync_detect_output_d = pix_sync_detect_i;
    output_pixel_clock_d = dual_q && !launch;
    if (!run) begin
      // Inputs disabled while powered down
      even_d = '0;
      odd_d = '0;
      de_d = 1'b0;
      hs_d = 1'b0;
      vs_d = 1'b0;
      ctl_d = '0;
      sync_detect_output_d = 1'b0;
      output_pixel_clock_d = 1'b0;
    end else if (launch) begin
      // Pixels, enable, syncs and controls move together on an output clock boundary
      if (dual_q) begin
        even_d = pair_even;
        odd_d[BLUE_LSB +: LANE_W] = pix_data_i[BLUE_LSB +: LANE_W];
        odd_d[GREEN_LSB +: LANE_W] = pix_data_i[GREEN_LSB +: LANE_W];
        odd_d[RED_LSB +: LANE_W] = pix_data_i[RED_LSB +: LANE_W];
      end else begin
        even_d[BLUE_LSB +: LANE_W] = pix_data_i[BLUE_LSB +: LANE_W];
        even_d[GREEN_LSB +: LANE_W] = pix_data_i[GREEN_LSB +: LANE_W];
        even_d[RED_LSB +: LANE_W] = pix_data_i[RED_LSB +: LANE_W];
        odd_d = '0;
      end
      de_d = pix_de_i;
      hs_d = pix_hsync_i;
      vs_d = pix_vsync_i;
      ctl_d = pix_ctl_i;
    end
  end

  // Pixel-side registers
  always_ff @(posedge pix_clk_i) begin
    pix_rst_q <= pix_rst_s;
    if (pix_rst_s) begin
      dual_q <= 1'b0;
      pol_q <= 1'b0;
      run_q <= 1'b0;
      even_q <= '0;
      odd_q <= '0;
      de_q <= 1'b0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      ctl_q <= '0;
      sync_detect_output_q <= 1'b0;
      output_pixel_clock_q <= 1'b0;
    end else begin
      dual_q <= dual_d;
      pol_q <= pol_d;
      run_q <= run_d;
      even_q <= even_d;
      odd_q <= odd_d;
      de_q <= de_d;
      hs_q <= hs_d;
      vs_q <= vs_d;
      ctl_q <= ctl_d;
      sync_detect_output_q <= sync_detect_output_d;
      output_pixel_clock_q <= output_pixel_clock_d;
    end
  end

  // State reported back to software
  always_comb begin
    stat_raw = '0;
    stat_raw[STAT_SYNC_DETECT_OUTPUT_BIT] = sync_detect_output_q;
    stat_raw[STAT_DUAL_BIT] = dual_q;
    stat_raw[STAT_POL_BIT] = pol_q;
    stat_raw[STAT_RUN_BIT] = run_q;
  end

  // Data changes on the rising pixel edge, so the latching edge sits
  // mid-cell. Single mode passes the pixel clock through a mux, which
  // is only glitch free while the straps stay still
  always_comb begin
    if (dual_q) begin
      output_pixel_clock_o = pol_q ? output_pixel_clock_q : !output_pixel_clock_q;
    end else begin
      output_pixel_clock_o = pol_q ? !pix_clk_i : pix_clk_i;
    end
  end

  assign even_pixel_bus_o = even_q;
  assign odd_pixel_bus_o = odd_q;
  assign display_enable_out_o = de_q;
  assign hsync_o = hs_q;
  assign vsync_o = vs_q;
  assign general_control_outputs_o = ctl_q;
  assign sync_detect_output_o = sync_detect_output_q;

  // Checks
  // Dual mode: output clock edge one pixel clock after each launch
  property p_clk_pol_dual;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (run && dual_q && launch) |=> (output_pixel_clock_o == !pol_q);
  endproperty
  a_clk_pol_dual: assert property (p_clk_pol_dual)
    else $error("output clock phase wrong after launch");

  // A control write clearing power floats all pads next edge
  property p_pd_float;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_wr && !wb_dat_i[CTRL_PD_BIT]) |=>
        !(even_pixel_bus_oe_o || odd_pixel_bus_oe_o || timing_oe_o ||
          output_pixel_clock_oe_o || sync_detect_output_oe_o ||
          (|general_control_outputs_oe_o));
  endproperty
  a_pd_float: assert property (p_pd_float)
    else $error("pads still driven in power down");

  // Path stays cleared whatever the inputs do
  property p_pd_ignore;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (!run_q) |=> (even_q == '0 && de_q == 1'b0 && output_pixel_clock_q == 1'b0 && ctl_q == '0);
  endproperty
  a_pd_ignore: assert property (p_pd_ignore)
    else $error("inputs reached outputs in power down");

  // Drive power down keeps only sync detect and control line 1
  property p_pdo_keep;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_q[CTRL_PD_BIT] && !ctrl_q[CTRL_PDO_BIT]) |->
        (!even_pixel_bus_oe_o && !odd_pixel_bus_oe_o && !timing_oe_o &&
         general_control_outputs_oe_o == 3'h1 && sync_detect_output_oe_o);
  endproperty
  a_pdo_keep: assert property (p_pdo_keep)
    else $error("wrong pads kept in drive power down");

  // First two pixels of a line leave together as one pair
  sequence s_line_start;
    run && dual_q && pix_de_i && !$past(pix_de_i);
  endsequence
  sequence s_second;
    run && dual_q && pix_de_i;
  endsequence
  property p_dual_pair;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      s_line_start ##1 s_second |=>
        (even_q == $past(pix_data_i, 2) && odd_q == $past(pix_data_i, 1) && de_q);
  endproperty
  a_dual_pair: assert property (p_dual_pair)
    else $error("dual mode pair misassembled");

  // Single mode: each lane carries the pixel of the previous cycle
  property p_single_lanes;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (run && !dual_q) |=>
        (even_q[BLUE_LSB +: LANE_W] == $past(pix_data_i[BLUE_LSB +: LANE_W]) &&
         even_q[GREEN_LSB +: LANE_W] == $past(pix_data_i[GREEN_LSB +: LANE_W]) &&
         even_q[RED_LSB +: LANE_W] == $past(pix_data_i[RED_LSB +: LANE_W]));
  endproperty
  a_single_lanes: assert property (p_single_lanes)
    else $error("single mode lane mismatch");

  // Odd bus held low from the second consecutive cycle of single mode on
  property p_odd_low;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (!dual_q) [*2] |-> (odd_q == '0);
  endproperty
  a_odd_low: assert property (p_odd_low)
    else $error("odd bus driven in single mode");

  // Between launches the pixel buses, horizontal sync and control lines hold still
  property p_hold_between;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (run && dual_q && !launch) |=>
        ($stable(even_q) && $stable(odd_q) && $stable(hs_q) && $stable(ctl_q));
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("outputs moved off the output clock");

  // Display enable follows the enable of the launched pixel
  property p_de_follow;
    @(posedge pix_clk_i) disable iff (pix_rst_q)
      (run && launch) |=> (de_q == $past(pix_de_i));
  endproperty
  a_de_follow: assert property (p_de_follow)
    else $error("display enable out of step");

  // Bus answer: one cycle ack, then released
  property p_wb_ack;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !ack_q) |=> ack_q ##1 !ack_q;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus acknowledge malformed");

endmodule // dvrpos_top

// File: test/dvrpos_panel_model.sv
// Panel-side sink that latches the pixel stage outputs on the chosen output clock edge
`timescale 1ns/1ps

module dvrpos_panel_model import dvrpos_pkg::*; (
  input wire logic latch_rise_i, // High: latch on rising output clock edge
  input wire logic pclk_i, // Output pixel clock as seen at the pad
  input wire logic [PIX_W-1:0] even_i, // Even bus pad level
  input wire logic [PIX_W-1:0] odd_i, // Odd bus pad level
  input wire logic enable_i, // Display enable pad level
  output logic [PIX_W-1:0] even_o, // Last latched even pixel
  output logic [PIX_W-1:0] odd_o, // Last latched odd pixel
  output logic enable_o // Last latched display enable
);
  // One process for both edges, so the capture has a single driver
  always @(pclk_i) begin
    if (pclk_i === latch_rise_i) begin
      even_o <= even_i;
      odd_o <= odd_i;
      enable_o <= enable_i;
    end
  end
endmodule // dvrpos_panel_model

// File: test/tb_dvrpos_top.sv
// Self-checking bench of the pixel output stage with its control port
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_dvrpos_top import dvrpos_pkg::*;;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o, rdat;
  logic pix_clk_i, pix_de_i, pix_hsync_i, pix_vsync_i, pix_sync_detect_i;
  logic [PIX_W-1:0] pix_data_i, even_bus, odd_bus, even_pad, odd_pad, cap_even, cap_odd;
  logic [CTL_W-1:0] pix_ctl_i, ctl_out, ctl_oe;
  logic even_oe, odd_oe, oclk, oclk_oe, en_out, hs_out, vs_out, tim_oe, sd_out, sd_oe;
  logic en_pad, cap_en, latch_rise;
  int bad_count = 0;
  int n_compared = 0;

  dvrpos_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_clk_i(pix_clk_i), .pix_data_i(pix_data_i),
    .pix_de_i(pix_de_i), .pix_hsync_i(pix_hsync_i), .pix_vsync_i(pix_vsync_i),
    .pix_ctl_i(pix_ctl_i), .pix_sync_detect_i(pix_sync_detect_i),
    .even_pixel_bus_o(even_bus), .even_pixel_bus_oe_o(even_oe), .odd_pixel_bus_o(odd_bus),
    .odd_pixel_bus_oe_o(odd_oe), .output_pixel_clock_o(oclk), .output_pixel_clock_oe_o(oclk_oe),
    .display_enable_out_o(en_out), .hsync_o(hs_out), .vsync_o(vs_out), .timing_oe_o(tim_oe),
    .general_control_outputs_o(ctl_out), .general_control_outputs_oe_o(ctl_oe),
    .sync_detect_output_o(sd_out), .sync_detect_output_oe_o(sd_oe));

  // Pads float when their driver is off, so the panel never sees stale data
  assign even_pad = even_oe ? even_bus : 'z;
  assign odd_pad = odd_oe ? odd_bus : 'z;
  assign en_pad = tim_oe ? en_out : 1'bz;

  dvrpos_panel_model panel_u (.latch_rise_i(latch_rise), .pclk_i(oclk), .even_i(even_pad),
    .odd_i(odd_pad), .enable_i(en_pad), .even_o(cap_even), .odd_o(cap_odd), .enable_o(cap_en));

  // System clock 4 ns; pixel clock 125 ns with an unrelated phase
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    pix_clk_i = 1'b0;
    #7.3;
    forever #62.5 pix_clk_i = ~pix_clk_i;
  end

  // Verdict in one place
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      results();
    end else begin
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  task automatic set_ctrl(input logic [3:0] v);
    wb_xfer(1'b1, REG_CTRL, {28'h0, v});
  endtask

  task automatic pix_wait(input int n);
    repeat (n) @(posedge pix_clk_i);
    @(negedge pix_clk_i);
  endtask

  // One line of distinct pixels, outputs checked every pixel cycle
  task automatic run_line(input logic dual, input int len);
    logic [23:0] p [0:15];
    int o;
    for (int i = 0; i < len; i++) p[i] = {8'h20 + 8'(i), 8'h50 + 8'(i), 8'h90 + 8'(i)};
    for (int i = 0; i <= len; i++) begin
      @(posedge pix_clk_i);
      // Panel latched on the previous falling edge, before this edge's update
      if (!dual && i >= 2) `CHK(cap_even, p[i-2])
      pix_de_i <= (i < len);
      pix_data_i <= (i < len) ? p[i] : 24'h0;
      @(negedge pix_clk_i);
      if (!dual && i >= 1) begin
        `CHK(even_bus, p[i-1])
        `CHK(odd_bus, 24'h0)
        `CHK(en_out, 1'b1)
      end
      if (dual && i >= 2) begin
        o = ((i - 1) % 2 == 1) ? i - 1 : i - 2;
        `CHK(even_bus, p[o-1])
        `CHK(odd_bus, p[o])
        `CHK(en_out, 1'b1)
      end
      if (dual && i >= 3 && i % 2 == 1) begin
        `CHK(cap_even, p[i-3])
        `CHK(cap_odd, p[i-2])
        `CHK(cap_en, 1'b1)
      end
    end
    pix_wait(3);
    `CHK(en_out, 1'b0)
  endtask

  // Power down with the old straps, restrap, then power up; each step
  // is held long enough for the pixel side to see it
  task automatic restrap(input logic [1:0] straps);
    wb_xfer(1'b0, REG_CTRL, 32'h0);
    set_ctrl({2'b10, rdat[1:0]});
    pix_wait(4);
    set_ctrl({2'b10, straps});
    pix_wait(4);
    set_ctrl({2'b11, straps});
    latch_rise = straps[1];
    pix_wait(10);
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    results();
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    {pix_de_i, pix_hsync_i, pix_vsync_i, pix_ctl_i} = 6'h00;
    pix_data_i = 24'h0;
    pix_sync_detect_i = 1'b1;
    latch_rise = 1'b0;
    // Reset must span several pixel clock edges as well
    repeat (130) @(posedge clk_i);
    rst_i <= 1'b0;
    pix_wait(10);
    wb_xfer(1'b0, REG_CTRL, 32'h0);
    `CHK(rdat, 32'h0000000c)
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rdat, 32'h00000009)
    wb_xfer(1'b1, REG_STATUS, 32'hffffffff);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rdat, 32'h00000009)
    wb_xfer(1'b0, 8'h08, 32'h0);
    `CHK(rdat, 32'h00000000)
    `CHK({even_oe, odd_oe, oclk_oe, tim_oe, ctl_oe, sd_oe}, 8'hff)
    // Blanking: syncs and controls pass through on the output clock
    @(posedge pix_clk_i);
    {pix_hsync_i, pix_vsync_i, pix_ctl_i} <= 5'b10101;
    pix_wait(1);
    `CHK({hs_out, vs_out, ctl_out}, 5'b10101)
    run_line(1'b0, 6);
    restrap(2'b11);
    run_line(1'b1, 8);
    restrap(2'b01);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rdat, 32'h0000000b)
    run_line(1'b1, 8);
    // Back to single mode, then full power down floats every pad and
    // ignores the pixel inputs; pad enables settle after the write edge
    restrap(2'b00);
    set_ctrl(4'h8);
    @(negedge clk_i);
    `CHK({even_oe, odd_oe, oclk_oe, tim_oe, ctl_oe, sd_oe}, 8'h00)
    @(posedge pix_clk_i);
    pix_de_i <= 1'b1;
    pix_data_i <= 24'hffffff;
    pix_wait(8);
    `CHK({even_bus, odd_bus, en_out}, 49'h0)
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rdat[3], 1'b0)
    // Driver power down keeps sync detect and control line one alive
    set_ctrl(4'h4);
    @(posedge pix_clk_i);
    pix_ctl_i <= 3'b111;
    pix_wait(8);
    `CHK({even_oe, odd_oe, oclk_oe, tim_oe}, 4'h0)
    `CHK({ctl_oe, sd_oe}, 4'b0011)
    `CHK({ctl_out[0], sd_out}, 2'b11)
    set_ctrl(4'hc);
    results();
  end
endmodule // tb_dvrpos_top
